// ### rtl/mtap_pkg.sv
// Purpose: shared constants for the memory test access port
// Assumes: 50 MHz system clock, test clock sampled as a level
// Notes: identification code fields are arbitrary neutral values
package mtap_pkg;
    // tap controller states
    typedef enum logic [3:0]
    {
        ST_RESET = 4'h0,
        ST_IDLE = 4'h1,
        ST_SEL_DR = 4'h2,
        ST_CAP_DR = 4'h3,
        ST_SHF_DR = 4'h4,
        ST_EX1_DR = 4'h5,
        ST_PAU_DR = 4'h6,
        ST_EX2_DR = 4'h7,
        ST_UPD_DR = 4'h8,
        ST_SEL_IR = 4'h9,
        ST_CAP_IR = 4'ha,
        ST_SHF_IR = 4'hb,
        ST_EX1_IR = 4'hc,
        ST_PAU_IR = 4'hd,
        ST_EX2_IR = 4'he,
        ST_UPD_IR = 4'hf
    } mtap_state_t;
    localparam int IR_W = 3;
    localparam logic [2:0] INS_EXTEST = 3'h0;
    localparam logic [2:0] INS_IDENT = 3'h1;
    localparam logic [2:0] INS_SAMPZ = 3'h2;
    localparam logic [2:0] INS_SAMPLE = 3'h4;
    localparam logic [2:0] INS_BYPASS = 3'h7;
    localparam logic [1:0] IR_CAPTURE = 2'h1;
    localparam int ID_W = 32;
    // arbitrary neutral identification value, bit 0 set as required
    localparam logic [31:0] ID_CODE = 32'h0abc_d001;
    localparam int BSR_PINS = 8;
    localparam int BSR_FILL = 2;
    localparam int BSR_W = BSR_PINS + BSR_FILL;
    localparam int RESET_ONES = 5;
endpackage

// ### rtl/mtap_shreg.sv
// Purpose: capture and shift register, lsb toward the serial output
// Assumes: capture and shift strobes are one-cycle, exclusive
// Notes: capture wins over shift
`timescale 1ns/1ps
module mtap_shreg #(
    parameter int W = 32
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cap,
    input wire logic shf,
    input wire logic sin,
    input wire logic [W-1:0] pdata,
    output logic [W-1:0] q
);
    // capture parallel word or shift toward bit 0
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            q <= '0;
        else if (cap)
            q <= pdata;
        else if (shf)
            q <= {sin, q[W-1:1]};
    end
endmodule

// ### rtl/mtap_sync.sv
// Purpose: two flip-flop synchroniser for one level
// Assumes: input is asynchronous to clock
// Notes: reset value is a parameter so pulled-up pins idle high
`timescale 1ns/1ps
module mtap_sync #(
    parameter logic INIT = 1'b1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    logic meta_q;
    // two stages, only the second is read
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= INIT;
            dout <= INIT;
        end
        else
        begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

// ### rtl/mtap_top.sv
// Purpose: boundary-scan test access port of a memory device
// Assumes: test pins sampled by 50 MHz clock; pull-ups modelled by tms_driven and tdi_driven flags
// Notes: all tap events happen on detected test clock edges
`timescale 1ns/1ps
module mtap_top (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tms_driven,
    input wire logic tdi,
    input wire logic tdi_driven,
    input wire logic [mtap_pkg::BSR_PINS-1:0] pin_level,
    output logic tdo,
    output logic tdo_oe,
    output logic mem_out_float,
    output logic extest_drive,
    output logic [mtap_pkg::BSR_PINS-1:0] bsr_out,
    output logic [2:0] instr_q,
    output logic [3:0] state_q
);
    import mtap_pkg::*;

    // ==========================================
    // pin synchronisers
    logic tck_s, tms_s, tdi_s, tmsd_s, tdid_s;
    logic tck_d1_q;
    logic [BSR_PINS-1:0] pin_s;
    logic tms_eff, tdi_eff;
    logic rise, fall;

    // test clock is pulled up and idles high, so no false edge follows reset
    mtap_sync #(.INIT(1'b1)) u_tck (.clock(clock), .rst_n(rst_n), .din(tck), .dout(tck_s));
    mtap_sync #(.INIT(1'b1)) u_tms (.clock(clock), .rst_n(rst_n), .din(tms), .dout(tms_s));
    mtap_sync #(.INIT(1'b1)) u_tdi (.clock(clock), .rst_n(rst_n), .din(tdi), .dout(tdi_s));
    mtap_sync #(.INIT(1'b0)) u_tmd (.clock(clock), .rst_n(rst_n), .din(tms_driven),
        .dout(tmsd_s));
    mtap_sync #(.INIT(1'b0)) u_tdd (.clock(clock), .rst_n(rst_n), .din(tdi_driven),
        .dout(tdid_s));

    genvar gi;
    generate
        for (gi = 0; gi < BSR_PINS; gi++)
        begin : g_pin
            mtap_sync #(.INIT(1'b0)) u_pin (.clock(clock), .rst_n(rst_n),
                .din(pin_level[gi]), .dout(pin_s[gi]));
        end
    endgenerate

    assign tms_eff = tmsd_s ? tms_s : 1'b1;
    assign tdi_eff = tdid_s ? tdi_s : 1'b1;

    // test clock edge detect
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            tck_d1_q <= 1'b1;
        else
            tck_d1_q <= tck_s;
    end
    // state and register events on detected rising edge, update and output events on falling edge
    assign rise = tck_s & ~tck_d1_q;
    assign fall = ~tck_s & tck_d1_q;

    // ==========================================
    // tap state machine
    mtap_state_t st_q, st_d;

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            ST_RESET: st_d = tms_eff ? ST_RESET : ST_IDLE;
            ST_IDLE: st_d = tms_eff ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: st_d = tms_eff ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: st_d = tms_eff ? ST_EX1_DR : ST_SHF_DR;
            ST_SHF_DR: st_d = tms_eff ? ST_EX1_DR : ST_SHF_DR;
            ST_EX1_DR: st_d = tms_eff ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: st_d = tms_eff ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: st_d = tms_eff ? ST_UPD_DR : ST_SHF_DR;
            ST_UPD_DR: st_d = tms_eff ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: st_d = tms_eff ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: st_d = tms_eff ? ST_EX1_IR : ST_SHF_IR;
            ST_SHF_IR: st_d = tms_eff ? ST_EX1_IR : ST_SHF_IR;
            ST_EX1_IR: st_d = tms_eff ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: st_d = tms_eff ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: st_d = tms_eff ? ST_UPD_IR : ST_SHF_IR;
            ST_UPD_IR: st_d = tms_eff ? ST_SEL_DR : ST_IDLE;
            default: st_d = ST_RESET;
        endcase
    end

    // advance on rising edge; reset, hold without edges
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= ST_RESET;
        else if (rise)
            st_q <= st_d;
    end
    assign state_q = st_q;

    // ==========================================
    // instruction register
    logic [IR_W-1:0] ir_sh_q;
    logic cap_ir, shf_ir, cap_dr, shf_dr;
    assign cap_ir = rise && st_q == ST_CAP_IR;
    assign shf_ir = rise && st_q == ST_SHF_IR;
    assign cap_dr = rise && st_q == ST_CAP_DR;
    assign shf_dr = rise && st_q == ST_SHF_DR;

    // instruction shift stage, loads only while selected
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            ir_sh_q <= INS_IDENT;
        else if (cap_ir)
            ir_sh_q <= {ir_sh_q[2], IR_CAPTURE};
        else if (shf_ir)
            ir_sh_q <= {tdi_eff, ir_sh_q[2:1]};
    end

    // preset on reset entry; new code applied at update
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            instr_q <= INS_IDENT;
        else if (rise && st_d == ST_RESET)
            instr_q <= INS_IDENT;
        else if (fall && st_q == ST_UPD_IR)
            instr_q <= ir_sh_q;
    end

    // ==========================================
    // data registers
    logic sel_bsr, sel_id, sel_byp;
    assign sel_bsr = instr_q == INS_EXTEST || instr_q == INS_SAMPZ || instr_q == INS_SAMPLE;
    assign sel_id = instr_q == INS_IDENT;
    assign sel_byp = !sel_bsr && !sel_id;

    logic byp_q;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            byp_q <= 1'b0;
        else if (cap_dr && sel_byp)
            byp_q <= 1'b0;
        else if (shf_dr && sel_byp)
            byp_q <= tdi_eff;
    end

    logic [ID_W-1:0] id_q;
    mtap_shreg #(.W(ID_W)) u_id (.clock(clock), .rst_n(rst_n), .cap(cap_dr && sel_id),
        .shf(shf_dr && sel_id), .sin(tdi_eff), .pdata(ID_CODE), .q(id_q));

    logic [BSR_W-1:0] bsr_q;
    // pins captured, filler cells capture one
    mtap_shreg #(.W(BSR_W)) u_bsr (.clock(clock), .rst_n(rst_n), .cap(cap_dr && sel_bsr),
        .shf(shf_dr && sel_bsr), .sin(tdi_eff), .pdata({{BSR_FILL{1'b1}}, pin_s}),
        .q(bsr_q));

    // boundary output latch for external test, updated at update-dr
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            bsr_out <= '0;
        else if (fall && st_q == ST_UPD_DR && sel_bsr)
            bsr_out <= bsr_q[BSR_PINS-1:0];
    end

    // float and drive controls follow the active instruction
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_out_float <= 1'b0;
            extest_drive <= 1'b0;
        end
        else
        begin
            mem_out_float <= instr_q == INS_SAMPZ && st_q != ST_RESET;
            extest_drive <= instr_q == INS_EXTEST && st_q != ST_RESET;
        end
    end

    // ==========================================
    // serial output
    logic tdo_src;
    // exactly one register feeds the output
    always_comb
    begin
        tdo_src = byp_q;
        if (st_q == ST_SHF_IR)
            tdo_src = ir_sh_q[0];
        else if (sel_id)
            tdo_src = id_q[0];
        else if (sel_bsr)
            tdo_src = bsr_q[0];
    end

    // output updates on falling edge, enabled only in shift
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end
        else if (fall)
        begin
            tdo <= tdo_src;
            tdo_oe <= st_q == ST_SHF_DR || st_q == ST_SHF_IR;
        end
    end

    // ==========================================
    // checks
    localparam logic [2:0] ONES_MAX = 3'(RESET_ONES);
    logic [2:0] ones_q;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            ones_q <= '0;
        else if (rise)
            ones_q <= tms_eff ? ((ones_q == ONES_MAX) ? ones_q : ones_q + 3'h1) : 3'h0;
    end

    // controller, register and serial output checks
    a_five_ones_reset: assert property (@(posedge clock) disable iff (!rst_n)
        ones_q == ONES_MAX |-> st_q == ST_RESET)
        else $error("five high mode clocks did not reset");
    a_tdo_fall_only: assert property (@(posedge clock) disable iff (!rst_n)
        !fall |=> $stable(tdo) && $stable(tdo_oe))
        else $error("serial output changed off a falling edge");
    a_state_hold: assert property (@(posedge clock) disable iff (!rst_n)
        !rise |=> $stable(st_q))
        else $error("state moved without test clock edge");
    a_reset_ident: assert property (@(posedge clock) disable iff (!rst_n)
        st_q == ST_RESET |-> instr_q == INS_IDENT)
        else $error("reset did not preset identification");
    a_cap_ir_pat: assert property (@(posedge clock) disable iff (!rst_n)
        cap_ir |=> ir_sh_q[1:0] == IR_CAPTURE)
        else $error("capture instruction pattern wrong");
    a_id_capture: assert property (@(posedge clock) disable iff (!rst_n)
        cap_dr && sel_id |=> id_q == ID_CODE)
        else $error("identification code not captured");
    a_fill_ones: assert property (@(posedge clock) disable iff (!rst_n)
        cap_dr && sel_bsr |=> bsr_q[BSR_W-1:BSR_PINS] == '1)
        else $error("filler cells did not capture one");
    a_bypass_stage: assert property (@(posedge clock) disable iff (!rst_n)
        shf_dr && sel_byp |=> byp_q == $past(tdi_eff))
        else $error("bypass did not take input");
    a_tms_pullup: assert property (@(posedge clock) disable iff (!rst_n)
        rise && !tmsd_s && st_q == ST_SHF_DR |=> st_q == ST_EX1_DR)
        else $error("undriven mode select not one");
    a_tdo_enable: assert property (@(posedge clock) disable iff (!rst_n)
        fall && !(st_q == ST_SHF_DR || st_q == ST_SHF_IR) |=> !tdo_oe)
        else $error("output enabled outside shift");
    // instruction path checks
    a_ir_load_sel: assert property (@(posedge clock) disable iff (!rst_n)
        !cap_ir && !shf_ir |=> $stable(ir_sh_q))
        else $error("instruction stage changed while not selected");
    a_ir_shift: assert property (@(posedge clock) disable iff (!rst_n)
        shf_ir |=> ir_sh_q == {$past(tdi_eff), $past(ir_sh_q[2:1])})
        else $error("instruction stage did not shift");
    a_tdo_ir: assert property (@(posedge clock) disable iff (!rst_n)
        fall && st_q == ST_SHF_IR |=> tdo == $past(ir_sh_q[0]))
        else $error("instruction stage not on serial output");
    a_instr_update: assert property (@(posedge clock) disable iff (!rst_n)
        fall && st_q == ST_UPD_IR |=> instr_q == $past(ir_sh_q))
        else $error("instruction not applied at update");
    a_instr_steady: assert property (@(posedge clock) disable iff (!rst_n)
        !(fall && st_q == ST_UPD_IR) && !(rise && st_d == ST_RESET) |=> $stable(instr_q))
        else $error("instruction changed outside update");
    // data register checks
    a_bsr_capture: assert property (@(posedge clock) disable iff (!rst_n)
        cap_dr && instr_q == INS_SAMPLE |=> bsr_q[BSR_PINS-1:0] == $past(pin_s))
        else $error("boundary cells did not capture pins");
    a_bsr_latch: assert property (@(posedge clock) disable iff (!rst_n)
        fall && st_q == ST_UPD_DR && sel_bsr |=> bsr_out == $past(bsr_q[BSR_PINS-1:0]))
        else $error("boundary output latch not updated");
    a_id_lsb: assert property (@(posedge clock) disable iff (!rst_n)
        fall && st_q == ST_SHF_DR && sel_id |=> tdo == $past(id_q[0]))
        else $error("identification bit zero not on serial output");
    a_byp_capture: assert property (@(posedge clock) disable iff (!rst_n)
        cap_dr && sel_byp |=> !byp_q)
        else $error("bypass did not capture zero");
    a_bypass_code: assert property (@(posedge clock) disable iff (!rst_n)
        fall && st_q == ST_SHF_DR && instr_q == INS_BYPASS |=> tdo == $past(byp_q))
        else $error("bypass code did not select bypass");
    a_tdo_oe_shift: assert property (@(posedge clock) disable iff (!rst_n)
        fall && (st_q == ST_SHF_DR || st_q == ST_SHF_IR) |=> tdo_oe)
        else $error("output not enabled in shift");
    // pin control checks
    a_reset_exit: assert property (@(posedge clock) disable iff (!rst_n)
        rise && st_q == ST_RESET && !tms_eff |=> st_q == ST_IDLE)
        else $error("reset state did not leave on low mode");
    a_float_sampz: assert property (@(posedge clock) disable iff (!rst_n)
        instr_q == INS_SAMPZ && st_q != ST_RESET |=> mem_out_float)
        else $error("outputs not floated by floating sample");
    a_float_off: assert property (@(posedge clock) disable iff (!rst_n)
        instr_q != INS_SAMPZ |=> !mem_out_float)
        else $error("outputs floated by another instruction");
    a_extest_drive: assert property (@(posedge clock) disable iff (!rst_n)
        instr_q == INS_EXTEST && st_q != ST_RESET |=> extest_drive)
        else $error("external test did not drive");
    // scenario covers
    c_shift_dr: cover property (@(posedge clock) disable iff (!rst_n) shf_dr && sel_id);
    c_update_ir: cover property (@(posedge clock) disable iff (!rst_n)
        fall && st_q == ST_UPD_IR);
    c_sampz: cover property (@(posedge clock) disable iff (!rst_n) mem_out_float);
    c_reset_entry: cover property (@(posedge clock) disable iff (!rst_n)
        rise && st_d == ST_RESET && st_q != ST_RESET);
    c_bsr_update: cover property (@(posedge clock) disable iff (!rst_n)
        fall && st_q == ST_UPD_DR && sel_bsr);
endmodule

// ### testbench/memory_test_access_port_tb.sv
// Purpose: self-checking bench for the memory test access port
// Assumes: scan controller model drives the test pins
// Notes: every instruction code is loaded and its data register scanned
`timescale 1ns/1ps
module memory_test_access_port_tb;
    import mtap_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] pin_level = 8'h00;
    logic tck, tms, tms_driven, tdi, tdi_driven;
    logic tdo, tdo_oe, mem_out_float, extest_drive;
    logic [7:0] bsr_out;
    logic [2:0] instr_q;
    logic [3:0] state_q;
    int bad_count = 0;
    int n_compared = 0;

    always #10 clock = ~clock;

    mtap_top u_dut (.clock(clock), .rst_n(rst_n), .tck(tck), .tms(tms),
        .tms_driven(tms_driven), .tdi(tdi), .tdi_driven(tdi_driven),
        .pin_level(pin_level), .tdo(tdo), .tdo_oe(tdo_oe),
        .mem_out_float(mem_out_float), .extest_drive(extest_drive),
        .bsr_out(bsr_out), .instr_q(instr_q), .state_q(state_q));

    mtap_scan_ctl u_ctl (.clock(clock), .tdo(tdo), .tck(tck), .tms(tms),
        .tms_driven(tms_driven), .tdi(tdi), .tdi_driven(tdi_driven));

    // ==========
    // tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (bad_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // scan n bits through data or instruction path, idle to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
        output logic [31:0] dout);
        logic o;
        dout = '0;
        u_ctl.step(1'b1, 1'b1, o);
        if (ir)
            u_ctl.step(1'b1, 1'b1, o);
        u_ctl.step(1'b0, 1'b1, o);
        u_ctl.step(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++)
        begin
            u_ctl.step(i == n - 1, din[i], o);
            dout[i] = o;
            check(tdo_oe, 1'b1);
        end
        u_ctl.step(1'b1, 1'b1, o);
        u_ctl.step(1'b0, 1'b1, o);
        check(tdo_oe, 1'b0);
    endtask

    // ==========
    // watchdog
    initial
    begin
        repeat (60000) @(posedge clock);
        bad_count++;
        tally_and_finish();
    end

    // ==========
    // main sequence
    initial
    begin
        logic [31:0] r;
        logic o;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        pin_level <= 8'h5a;
        repeat (6) @(posedge clock);
        check(state_q, ST_RESET);
        check(instr_q, INS_IDENT);
        u_ctl.step(1'b0, 1'b1, o);
        scan(1'b0, 32, 32'h0, r);
        check(r, ID_CODE);
        for (int c = 0; c < 8; c++)
        begin
            scan(1'b1, 3, c, r);
            check(r[1:0], IR_CAPTURE);
            check(instr_q, c[2:0]);
            check(mem_out_float, c == 2);
            check(extest_drive, c == 0);
            if (c == 0 || c == 2 || c == 4)
            begin
                scan(1'b0, 10, 32'h2c3, r);
                check(r[9:0], {2'b11, 8'h5a});
                check(bsr_out, 8'hc3);
            end
            else
            begin
                scan(1'b0, 32, 32'h155, r);
                if (c == 1)
                    check(r, ID_CODE);
                else
                    check(r, 32'h2aa);
            end
        end
        u_ctl.set_drive(1'b1, 1'b0);
        scan(1'b0, 8, 32'h0, r);
        check(r[7:0], 8'hfe);
        u_ctl.set_drive(1'b0, 1'b1);
        repeat (100) @(posedge clock);
        check(state_q, ST_IDLE);
        u_ctl.set_drive(1'b1, 1'b1);
        u_ctl.step(1'b1, 1'b1, o);
        u_ctl.step(1'b0, 1'b1, o);
        u_ctl.step(1'b0, 1'b1, o);
        u_ctl.set_drive(1'b0, 1'b1);
        repeat (4) u_ctl.step(1'b0, 1'b1, o);
        repeat (4) @(posedge clock);
        check(state_q, ST_SEL_IR);
        check(instr_q, INS_BYPASS);
        u_ctl.step(1'b0, 1'b1, o);
        repeat (4) @(posedge clock);
        check(state_q, ST_RESET);
        check(instr_q, INS_IDENT);
        u_ctl.set_drive(1'b1, 1'b1);
        u_ctl.step(1'b0, 1'b1, o);
        u_ctl.tap_reset();
        repeat (4) @(posedge clock);
        check(state_q, ST_RESET);
        tally_and_finish();
    end
endmodule

// ### testbench/mtap_scan_ctl.sv
// Purpose: behavioural scan controller driving the test pins
// Assumes: 50 MHz clock; test clock 160 ns, low 5 clocks, high 3
// Notes: a released pin reads zero, so only the device pull-up gives a one
`timescale 1ns/1ps
module mtap_scan_ctl (
    input wire logic clock,
    input wire logic tdo,
    output logic tck,
    output logic tms,
    output logic tms_driven,
    output logic tdi,
    output logic tdi_driven
);
    logic tms_v = 1'b1;
    logic tdi_v = 1'b1;

    // ==========
    // pin drive
    // released pins read zero so only the device pull-up can give a one
    assign tms = tms_driven ? tms_v : 1'b0;
    assign tdi = tdi_driven ? tdi_v : 1'b0;

    initial
    begin
        tck = 1'b1;
        tms_driven = 1'b1;
        tdi_driven = 1'b1;
    end

    // ==========
    // tasks
    // drive or release the mode and data pins
    task automatic set_drive(input logic m, input logic d);
        tms_driven <= m;
        tdi_driven <= d;
    endtask

    // one test clock; tck stands high between calls; tdo read before the rise
    task automatic step(input logic m, input logic d, output logic o);
        @(posedge clock);
        tck <= 1'b0;
        tms_v <= m;
        tdi_v <= d;
        repeat (5) @(posedge clock);
        o = tdo;
        tck <= 1'b1;
        repeat (2) @(posedge clock);
    endtask

    task automatic tap_reset();
        logic o;
        repeat (5) step(1'b1, 1'b1, o);
    endtask
endmodule
